// [design/dqs_pkg.sv]
// Package with offsets, status bit positions, timing and carrier types for the status and strobe bank
package dqs_pkg;
    localparam logic [4:0] OFS_STATUS       = 5'h00;
    localparam logic [4:0] OFS_START_CONV   = 5'h08;
    localparam logic [4:0] OFS_START_ACQ    = 5'h0a;
    localparam logic [4:0] OFS_ACQ_CLEAR    = 5'h0c;
    localparam logic [4:0] OFS_EXT_STROBE   = 5'h0e;
    localparam logic [4:0] OFS_DAC0         = 5'h10;
    localparam logic [4:0] OFS_DAC1         = 5'h12;
    localparam logic [4:0] OFS_DAC_UPD_CLR  = 5'h14;
    localparam logic [4:0] OFS_DMA_TC_CLR   = 5'h16;
    localparam logic [4:0] OFS_CONTROL      = 5'h18;

    localparam int BIT_SCAN_EMPTY_N   = 0;
    localparam int BIT_PROM_DESEL_N   = 2;
    localparam int BIT_PROM_OUT       = 3;
    localparam int BIT_CAL_LOCK_N     = 4;
    localparam int BIT_DAC_UPD_ERR    = 5;
    localparam int BIT_DAC_UPD_FLAG   = 6;
    localparam int BIT_OVERRUN_N      = 7;
    localparam int BIT_OVERFLOW_N     = 8;
    localparam int BIT_DMA_TC_B       = 9;
    localparam int BIT_DMA_TC_A       = 10;
    localparam int BIT_DMA_TC         = 11;
    localparam int BIT_FIFO_EMPTY_N   = 12;
    localparam int BIT_ACQ_BUSY       = 14;
    localparam int BIT_ACQ_COMPLETE   = 15;

    // Control register fields
    localparam int CTL_WAVEFORM_GEN_ENABLE           = 0;
    localparam int CTL_INT_MODE_LO    = 1;
    localparam int CTL_INT_MODE_W     = 2;
    localparam logic [1:0] MODE_NONE  = 2'h0;
    localparam logic [1:0] MODE_IRQ   = 2'h1;
    localparam logic [1:0] MODE_DMA   = 2'h2;
    localparam logic [7:0] CONTROL_RST = 8'h00;

    localparam int CAL_LOCKED_FIRST   = 52;
    localparam int CAL_DEPTH          = 64;

    localparam int CLK_MHZ            = 40;
    localparam int STROBE_NS          = 300;
    localparam int STROBE_CYCLES      = (STROBE_NS * CLK_MHZ + 999) / 1000;

    typedef struct packed {
        logic [4:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } dqs_bus_req_t;

    typedef struct packed {
        logic start_conv;
        logic start_acq;
        logic acq_clear;
        logic dac_update;
        logic dma_tc_clear;
    } dqs_events_t;
endpackage

// [design/dqs_pulse.sv]
// Fixed-length active-low pulse generator for the external strobe output
`timescale 1ns/1ps
module dqs_pulse #(
    parameter int CYCLES = dqs_pkg::STROBE_CYCLES
) (
    input  wire logic clk_sys_i,
    input  wire logic rst_b_i,
    input  wire logic fire_i,
    output logic      pulse_n_o
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LEN = CW'(CYCLES);
    logic [CW-1:0] cnt_ff;
    logic          pulse_n_ff;

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_ff <= '0;
        end else if (fire_i) begin
            cnt_ff <= LEN;
        end else if (cnt_ff != '0) begin
            cnt_ff <= cnt_ff - 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pulse_n_ff <= 1'b1;
        end else begin
            pulse_n_ff <= !(fire_i || (cnt_ff > CW'(1)));
        end
    end

    assign pulse_n_o = pulse_n_ff;
endmodule

// [design/dqs_sync.sv]
// Two-flip-flop synchroniser for a vector of asynchronous pins
`timescale 1ns/1ps
module dqs_sync #(
    parameter int W     = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clk_sys_i,
    input  wire logic         rst_b_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] q_ff;

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta_ff <= RST_VAL;
            q_ff    <= RST_VAL;
        end else begin
            meta_ff <= d_i;
            q_ff    <= meta_ff;
        end
    end

    assign q_o = q_ff;
endmodule

// [design/dqs_top.sv]
// Status word and event strobe register bank of the acquisition board
// Operation
// - DAC trigger falling edge sets update flag
// - Update flag requests only in chosen mode
// - Repeat update without new value flags error if control bit 0 set
// - Lock blocks writes to top calibration locations
// - Status bit 3 shows calibration serial out
// - Status bit 2 mirrors calibration chip select
// - Bit 0 low means scan list empty
// - Write offset 8 starts one conversion
// - External convert low blocks software start
// - Write offset A starts acquisition run
// - External trigger low blocks software start
// - Offset C clears acquisition, FIFO, flags
// - Offset E write pulses external strobe
// - Offset 16 clears DMA terminal counts
// - Error flags active low, stop acquisition
// - Update clear drops flag, error, request
// - Offset E read updates both DACs if control bit 0 set
`timescale 1ns/1ps
module dqs_top #(
    parameter int STROBE_CYCLES = dqs_pkg::STROBE_CYCLES
) (
    input  wire logic        clk_sys_i,
    input  wire logic        rst_b_i,
    // Register bus
    input  wire logic [4:0]  addr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [15:0] rdata_o,

    // Pins, synchronised inside
    input  wire logic        dac_update_trigger_n_i,
    input  wire logic        ext_convert_n_i,
    input  wire logic        ext_acq_trigger_n_i,
    input  wire logic        factory_cal_lock_n_i,
    input  wire logic        cal_prom_data_i,
    input  wire logic        cal_prom_cs_pin_i,

    // Calibration write gate
    input  wire logic [5:0]  cal_prom_addr_i,
    input  wire logic        cal_prom_write_req_i,
    output logic             cal_prom_write_en_o,

    // Scan and FIFO levels, synchronised inside
    input  wire logic        scan_list_has_entries_i,
    input  wire logic        sample_fifo_not_empty_i,

    // Same-clock events
    input  wire logic        fifo_overflow_i,
    input  wire logic        conv_overrun_i,
    input  wire logic        acq_done_i,
    input  wire logic        dma_tc_a_i,
    input  wire logic        dma_tc_b_i,

    // Pulses and requests
    output logic             start_conv_o,
    output logic             start_acq_o,
    output logic             acq_clear_o,
    output logic             scan_rewind_o,
    output logic             dac_update_o,
    output logic             acq_busy_o,
    output logic             dac_irq_o,
    output logic             dac_dma_req_o,
    output logic             dma_tc_irq_o,
    output logic             ext_strobe_out_n_o
);
    logic               rst_meta_ff;
    logic               rst_sync_ff;
    logic               rst_b;
    dqs_pkg::dqs_bus_req_t req;
    dqs_pkg::dqs_events_t  ev_ff;

    // Write decodes
    logic               hit_conv;
    logic               hit_acq;
    logic               hit_clear;
    logic               hit_strobe;
    logic               hit_tc_clear;
    logic               hit_dac_clear;
    logic               hit_dac_load;
    logic               hit_control;

    // Synchronised pins
    logic [7:0]         pins_s;
    logic               trig_prev_ff;
    logic               trig_fall;

    // DAC update tracking
    logic               dac_flag_ff;
    logic               dac_err_ff;
    logic               dac_fresh_ff;

    // Control and acquisition
    logic [7:0]         control_ff;
    logic               acq_busy_ff;
    logic               acq_comp_ff;
    logic               overflow_n_ff;
    logic               overrun_n_ff;
    logic               tc_a_ff;
    logic               tc_b_ff;

    // Read side
    logic [15:0]        status;
    logic [15:0]        rdata_ff;
    logic               waveform_gen_enable;
    logic [1:0]         int_mode;
    logic               ext_strobe_n;

    // Reset release through two flops
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end
    assign rst_b = rst_sync_ff;

    assign req.addr  = addr_i;
    assign req.wdata = wdata_i;
    assign req.wr    = wr_i;
    assign req.rd    = rd_i;

    function automatic logic wr_hit(input dqs_pkg::dqs_bus_req_t r, input logic [4:0] ofs);
        wr_hit = r.wr && (r.addr == ofs);
    endfunction

    assign hit_conv      = wr_hit(req, dqs_pkg::OFS_START_CONV);
    assign hit_acq       = wr_hit(req, dqs_pkg::OFS_START_ACQ);
    assign hit_clear     = wr_hit(req, dqs_pkg::OFS_ACQ_CLEAR);
    assign hit_strobe    = wr_hit(req, dqs_pkg::OFS_EXT_STROBE);
    assign hit_tc_clear  = wr_hit(req, dqs_pkg::OFS_DMA_TC_CLR);
    assign hit_dac_clear = wr_hit(req, dqs_pkg::OFS_DAC_UPD_CLR);
    assign hit_dac_load  = wr_hit(req, dqs_pkg::OFS_DAC0) || wr_hit(req, dqs_pkg::OFS_DAC1);
    assign hit_control   = wr_hit(req, dqs_pkg::OFS_CONTROL);

    // Pin order: trig, conv, acq, lock, prom data, prom cs, scan, fifo
    dqs_sync #(
        .W       (8),
        .RST_VAL (8'hff)
    ) u_sync (
        .clk_sys_i (clk_sys_i),
        .rst_b_i   (rst_b),
        .d_i       ({sample_fifo_not_empty_i,
                     scan_list_has_entries_i,
                     cal_prom_cs_pin_i,
                     cal_prom_data_i,
                     factory_cal_lock_n_i,
                     ext_acq_trigger_n_i,
                     ext_convert_n_i,
                     dac_update_trigger_n_i}),
        .q_o       (pins_s)
    );

    assign waveform_gen_enable     = control_ff[dqs_pkg::CTL_WAVEFORM_GEN_ENABLE];
    assign int_mode = control_ff[dqs_pkg::CTL_INT_MODE_LO +: dqs_pkg::CTL_INT_MODE_W];

    // Software control register
    always_ff @(posedge clk_sys_i or negedge rst_b) begin
        if (!rst_b) begin
            control_ff <= dqs_pkg::CONTROL_RST;
        end else if (hit_control) begin
            control_ff <= req.wdata[7:0];
        end
    end

    // Event strobes, data bits ignored
    always_ff @(posedge clk_sys_i or negedge rst_b) begin
        if (!rst_b) begin
            ev_ff <= '0;
        end else begin
            ev_ff.start_conv   <= hit_conv && pins_s[1];
            ev_ff.start_acq    <= hit_acq && pins_s[2];
            ev_ff.acq_clear    <= hit_clear;
            ev_ff.dac_update   <= (req.rd && req.addr == dqs_pkg::OFS_EXT_STROBE && waveform_gen_enable)
                                  || (trig_fall && waveform_gen_enable);
            ev_ff.dma_tc_clear <= hit_tc_clear;
        end
    end

    // Low external levels start conversions and runs themselves
    assign start_conv_o  = ev_ff.start_conv || !pins_s[1];
    assign start_acq_o   = ev_ff.start_acq || !pins_s[2];
    assign acq_clear_o   = ev_ff.acq_clear;
    assign scan_rewind_o = ev_ff.acq_clear;
    assign dac_update_o  = ev_ff.dac_update;

    // Trigger edge detect on synchronised copy
    always_ff @(posedge clk_sys_i or negedge rst_b) begin
        if (!rst_b) begin
            trig_prev_ff <= 1'b1;
        end else begin
            trig_prev_ff <= pins_s[0];
        end
    end
    assign trig_fall = trig_prev_ff && !pins_s[0];

    // Update flag: set wins over clear
    always_ff @(posedge clk_sys_i or negedge rst_b) begin
        if (!rst_b) begin
            dac_flag_ff <= 1'b0;
        end else if (trig_fall) begin
            dac_flag_ff <= 1'b1;
        end else if (hit_dac_clear) begin
            dac_flag_ff <= 1'b0;
        end
    end

    // Fresh value tracking for repeated updates
    always_ff @(posedge clk_sys_i or negedge rst_b) begin
        if (!rst_b) begin
            dac_fresh_ff <= 1'b0;
        end else if (hit_dac_load) begin
            dac_fresh_ff <= 1'b1;
        end else if (trig_fall) begin
            dac_fresh_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b) begin
        if (!rst_b) begin
            dac_err_ff <= 1'b0;
        end else if (trig_fall && waveform_gen_enable && !dac_fresh_ff) begin
            dac_err_ff <= 1'b1;
        end else if (hit_dac_clear) begin
            dac_err_ff <= 1'b0;
        end
    end

    assign dac_irq_o     = dac_flag_ff && (int_mode == dqs_pkg::MODE_IRQ);
    assign dac_dma_req_o = dac_flag_ff && (int_mode == dqs_pkg::MODE_DMA);

    // Calibration memory write protection
    assign cal_prom_write_en_o = cal_prom_write_req_i
                                 && (!pins_s[3] || (cal_prom_addr_i < 6'(dqs_pkg::CAL_LOCKED_FIRST)));

    // Active-low error flags, set wins over clear
    always_ff @(posedge clk_sys_i or negedge rst_b) begin
        if (!rst_b) begin
            overflow_n_ff <= 1'b1;
        end else if (fifo_overflow_i) begin
            overflow_n_ff <= 1'b0;
        end else if (ev_ff.acq_clear) begin
            overflow_n_ff <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b) begin
        if (!rst_b) begin
            overrun_n_ff <= 1'b1;
        end else if (conv_overrun_i) begin
            overrun_n_ff <= 1'b0;
        end else if (ev_ff.acq_clear) begin
            overrun_n_ff <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b) begin
        if (!rst_b) begin
            acq_busy_ff <= 1'b0;
        end else if (ev_ff.acq_clear || fifo_overflow_i || conv_overrun_i || acq_done_i) begin
            acq_busy_ff <= 1'b0;
        end else if (start_acq_o) begin
            acq_busy_ff <= 1'b1;
        end
    end
    assign acq_busy_o = acq_busy_ff;

    always_ff @(posedge clk_sys_i or negedge rst_b) begin
        if (!rst_b) begin
            acq_comp_ff <= 1'b0;
        end else if (acq_busy_ff && (acq_done_i || fifo_overflow_i || conv_overrun_i)) begin
            acq_comp_ff <= 1'b1;
        end else if (ev_ff.acq_clear) begin
            acq_comp_ff <= 1'b0;
        end
    end

    // DMA terminal count flags: set wins over clear
    always_ff @(posedge clk_sys_i or negedge rst_b) begin
        if (!rst_b) begin
            tc_a_ff <= 1'b0;
        end else begin
            tc_a_ff <= dma_tc_a_i || (tc_a_ff && !ev_ff.dma_tc_clear);
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b) begin
        if (!rst_b) begin
            tc_b_ff <= 1'b0;
        end else begin
            tc_b_ff <= dma_tc_b_i || (tc_b_ff && !ev_ff.dma_tc_clear);
        end
    end
    assign dma_tc_irq_o = tc_a_ff || tc_b_ff;

    // Status word assembly
    always_comb begin
        status                               = 16'h0000;
        status[dqs_pkg::BIT_SCAN_EMPTY_N]    = pins_s[6];
        status[dqs_pkg::BIT_PROM_DESEL_N]    = pins_s[5];
        status[dqs_pkg::BIT_PROM_OUT]        = pins_s[4];
        status[dqs_pkg::BIT_CAL_LOCK_N]      = pins_s[3];

        // Flags held in this block, and the FIFO level masked during clear
        status[dqs_pkg::BIT_DAC_UPD_ERR]     = dac_err_ff;
        status[dqs_pkg::BIT_DAC_UPD_FLAG]    = dac_flag_ff;
        status[dqs_pkg::BIT_OVERRUN_N]       = overrun_n_ff;
        status[dqs_pkg::BIT_OVERFLOW_N]      = overflow_n_ff;
        status[dqs_pkg::BIT_DMA_TC_B]        = tc_b_ff;
        status[dqs_pkg::BIT_DMA_TC_A]        = tc_a_ff;
        status[dqs_pkg::BIT_DMA_TC]          = tc_a_ff || tc_b_ff;
        status[dqs_pkg::BIT_FIFO_EMPTY_N]    = pins_s[7] && !ev_ff.acq_clear;
        status[dqs_pkg::BIT_ACQ_BUSY]        = acq_busy_ff;
        status[dqs_pkg::BIT_ACQ_COMPLETE]    = acq_comp_ff;
    end

    // Read data one cycle after the strobe, zero otherwise
    always_ff @(posedge clk_sys_i or negedge rst_b) begin
        if (!rst_b) begin
            rdata_ff <= 16'h0000;
        end else if (req.rd) begin
            case (req.addr)
                dqs_pkg::OFS_STATUS:  rdata_ff <= status;
                dqs_pkg::OFS_CONTROL: rdata_ff <= {8'h00, control_ff};
                default:              rdata_ff <= 16'h0000;
            endcase
        end else begin
            rdata_ff <= 16'h0000;
        end
    end
    assign rdata_o = rdata_ff;

    dqs_pulse #(
        .CYCLES (STROBE_CYCLES)
    ) u_pulse (
        .clk_sys_i (clk_sys_i),
        .rst_b_i   (rst_b),
        .fire_i    (hit_strobe),
        .pulse_n_o (ext_strobe_n)
    );
    assign ext_strobe_out_n_o = ext_strobe_n;
endmodule

// [tb/daq_status_and_event_strobes_bench.sv]
// Self-checking bench for the status word and event strobe bank
`timescale 1ns/1ps
module daq_status_and_event_strobes_bench;
    localparam int SC = 6;
    logic        clk_sys_i, rst_b_i, wr, rd, trig_n, conv_n, acqt_n, lock_n, pdata, pcs, preq, has_ent, fifo_ne;
    logic        ovf, ovr, done, tca, tcb, prom_en, s_conv, s_acq, clr, rew, dac_upd, busy, irq, dreq, tc_irq, stb_n;
    logic [4:0]  addr;
    logic [5:0]  paddr;
    logic [15:0] wdata, rdata, st;
    int          num_errors, comparisons, cyc, n;
    logic [7:0]  cal_tab [3] = '{8'hb4, 8'hf3, 8'h7f};

    dqs_top #(.STROBE_CYCLES(SC)) u_dut (
        .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata), .dac_update_trigger_n_i(trig_n), .ext_convert_n_i(conv_n), .ext_acq_trigger_n_i(acqt_n),
        .factory_cal_lock_n_i(lock_n), .cal_prom_data_i(pdata), .cal_prom_cs_pin_i(pcs), .cal_prom_addr_i(paddr),
        .cal_prom_write_req_i(preq), .cal_prom_write_en_o(prom_en), .scan_list_has_entries_i(has_ent),
        .sample_fifo_not_empty_i(fifo_ne), .fifo_overflow_i(ovf), .conv_overrun_i(ovr), .acq_done_i(done),
        .dma_tc_a_i(tca), .dma_tc_b_i(tcb), .start_conv_o(s_conv), .start_acq_o(s_acq), .acq_clear_o(clr),
        .scan_rewind_o(rew), .dac_update_o(dac_upd), .acq_busy_o(busy), .dac_irq_o(irq), .dac_dma_req_o(dreq),
        .dma_tc_irq_o(tc_irq), .ext_strobe_out_n_o(stb_n));
    dqs_host u_host (.clk_sys_i(clk_sys_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));

    initial begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wait_cyc(input int k);
        repeat (k) @(posedge clk_sys_i);
    endtask
    task automatic trig_pulse();
        @(posedge clk_sys_i);
        trig_n <= 1'b0;
        wait_cyc(3);
        trig_n <= 1'b1;
        wait_cyc(4);
    endtask
    task automatic final_report();
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic t_status();
        @(posedge clk_sys_i);
        {has_ent, pdata, pcs, lock_n, fifo_ne} <= 5'b11011;
        wait_cyc(4);
        u_host.rd_reg(dqs_pkg::OFS_STATUS, st);
        chk("status pins set", st & 16'h101f, 16'h1019);
        @(posedge clk_sys_i);
        {has_ent, pdata, pcs, lock_n, fifo_ne} <= 5'b00100;
        wait_cyc(4);
        u_host.rd_reg(dqs_pkg::OFS_STATUS, st);
        chk("status pins clear", st & 16'h101f, 16'h0004);
    endtask
    task automatic t_dac();
        for (int m = 0; m < 3; m++) begin
            u_host.wr_reg(dqs_pkg::OFS_CONTROL, 16'(m * 2 + 1));
            u_host.wr_reg(dqs_pkg::OFS_DAC_UPD_CLR, 16'h00ff);
            u_host.wr_reg(dqs_pkg::OFS_DAC0, 16'h0abc);
            trig_pulse();
            u_host.rd_reg(dqs_pkg::OFS_STATUS, st);
            chk("dac flag", st & 16'h0060, 16'h0040);
            chk("dac request", {14'h0, dreq, irq}, 16'(m));
        end
        trig_pulse();
        u_host.rd_reg(dqs_pkg::OFS_STATUS, st);
        chk("dac error", st & 16'h0060, 16'h0060);
        u_host.wr_reg(dqs_pkg::OFS_DAC_UPD_CLR, 16'h0000);
        u_host.rd_reg(dqs_pkg::OFS_STATUS, st);
        chk("dac cleared", {st & 16'h0060} | {14'h0, dreq, irq}, 16'h0000);
        u_host.rd_reg(dqs_pkg::OFS_EXT_STROBE, st);
        chk("dac update", {14'h0, dac_upd, stb_n}, 16'h0003);
        chk("update read data", st, 16'h0000);
    endtask
    task automatic t_starts();
        u_host.wr_reg(dqs_pkg::OFS_START_CONV, 16'h00ff);
        #1 chk("conv pulse", {15'h0, s_conv}, 16'h0001);
        @(posedge clk_sys_i);
        conv_n <= 1'b0;
        wait_cyc(4);
        #1 chk("conv level", {15'h0, s_conv}, 16'h0001);
        @(posedge clk_sys_i);
        conv_n <= 1'b1;
        u_host.wr_reg(dqs_pkg::OFS_START_ACQ, 16'h0000);
        #1 chk("acq pulse", {15'h0, s_acq}, 16'h0001);
        wait_cyc(2);
        #1 chk("acq busy", {15'h0, busy}, 16'h0001);
        @(posedge clk_sys_i);
        {ovf, acqt_n} <= 2'b10;
        @(posedge clk_sys_i);
        ovf <= 1'b0;
        #1 chk("overflow stops run", {15'h0, busy}, 16'h0000);
        wait_cyc(4);
        #1 chk("trigger level run", {14'h0, busy, s_acq}, 16'h0003);
        @(posedge clk_sys_i);
        acqt_n <= 1'b1;
    endtask
    task automatic t_clear();
        @(posedge clk_sys_i);
        {ovr, done} <= 2'b11;
        @(posedge clk_sys_i);
        {ovr, done} <= 2'b00;
        u_host.rd_reg(dqs_pkg::OFS_STATUS, st);
        chk("error flags low", st & 16'h8180, 16'h8000);
        u_host.wr_reg(dqs_pkg::OFS_START_ACQ, 16'h0000);
        u_host.wr_reg(dqs_pkg::OFS_ACQ_CLEAR, 16'h5a5a);
        #1 chk("clear pulses", {14'h0, clr, rew}, 16'h0003);
        u_host.rd_reg(dqs_pkg::OFS_STATUS, st);
        chk("flags after clear", st & 16'hc180, 16'h0180);
    endtask
    task automatic t_misc();
        @(posedge clk_sys_i);
        {tca, tcb} <= 2'b11;
        @(posedge clk_sys_i);
        {tca, tcb} <= 2'b00;
        u_host.rd_reg(dqs_pkg::OFS_STATUS, st);
        chk("tc flags", (st & 16'h0e00) | 16'(tc_irq), 16'h0e01);
        u_host.wr_reg(dqs_pkg::OFS_DMA_TC_CLR, 16'hffff);
        u_host.rd_reg(dqs_pkg::OFS_STATUS, st);
        chk("tc cleared", (st & 16'h0e00) | 16'(tc_irq), 16'h0000);
        u_host.wr_reg(dqs_pkg::OFS_EXT_STROBE, 16'h0000);
        #1 n = 0;
        while (stb_n === 1'b0 && n < 100) begin
            n++;
            @(posedge clk_sys_i);
            #1;
        end
        chk("strobe width", 16'(n), 16'(SC));
        foreach (cal_tab[i]) begin
            @(posedge clk_sys_i);
            {lock_n, preq, paddr} <= {cal_tab[i][7], 1'b1, cal_tab[i][5:0]};
            wait_cyc(3);
            #1 chk("cal write gate", {15'h0, prom_en}, {15'h0, cal_tab[i][6]});
        end
        @(posedge clk_sys_i);
        preq <= 1'b0;
        u_host.rd_reg(5'h1e, st);
        chk("unmapped read", st, 16'h0000);
        u_host.rd_reg(dqs_pkg::OFS_START_CONV, st);
        chk("strobe read", st, 16'h0000);
    endtask

    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 5000) begin
            num_errors++;
            final_report();
        end
    end

    initial begin
        {trig_n, conv_n, acqt_n, lock_n, pdata, pcs, preq, has_ent, fifo_ne} = 9'h1f9;
        {ovf, ovr, done, tca, tcb, paddr} = 11'h000;
        rst_b_i = 1'b0;
        wait_cyc(6);
        rst_b_i <= 1'b1;
        wait_cyc(3);
        t_status();
        t_dac();
        t_starts();
        t_clear();
        t_misc();
        final_report();
    end
endmodule

// [tb/dqs_host.sv]
// Host bus master model issuing one-cycle register strobes
`timescale 1ns/1ps
module dqs_host (
    input  wire logic        clk_sys_i,
    input  wire logic [15:0] rdata_i,
    output logic      [4:0]  addr_o,
    output logic      [15:0] wdata_o,
    output logic             wr_o,
    output logic             rd_o
);
    initial begin
        addr_o = 5'h1f;
        wdata_o = 16'h0000;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    // Data inverted once released so stale values are never mistaken for live ones
    task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk_sys_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge clk_sys_i);
        wr_o <= 1'b0;
        wdata_o <= ~d;
    endtask
    task automatic rd_reg(input logic [4:0] a, output logic [15:0] d);
        @(posedge clk_sys_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_sys_i);
        rd_o <= 1'b0;
        #1 d = rdata_i;
    endtask
endmodule

// [tb/dqs_top_monitor.sv]
// Concurrent checks on the ports of the status and strobe bank
`timescale 1ns/1ps
module dqs_top_monitor #(
    parameter int STROBE_CYCLES = 12
) (
    input  wire logic        clk_sys_i,
    input  wire logic        rst_b_i,
    input  wire logic [4:0]  addr_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    input  wire logic [15:0] rdata_o,
    input  wire logic        ext_convert_n_i,
    input  wire logic        ext_acq_trigger_n_i,
    input  wire logic        factory_cal_lock_n_i,
    input  wire logic [5:0]  cal_prom_addr_i,
    input  wire logic        cal_prom_write_req_i,
    input  wire logic        cal_prom_write_en_o,
    input  wire logic        dma_tc_a_i,
    input  wire logic        dma_tc_b_i,
    input  wire logic        start_conv_o,
    input  wire logic        start_acq_o,
    input  wire logic        acq_clear_o,
    input  wire logic        scan_rewind_o,
    input  wire logic        dma_tc_irq_o,
    input  wire logic        ext_strobe_out_n_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);
    logic [7:0] since_ff;
    // Cycles since the last strobe write, saturating
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            since_ff <= 8'hff;
        end else if (wr_i && addr_i == dqs_pkg::OFS_EXT_STROBE) begin
            since_ff <= 8'h01;
        end else if (since_ff != 8'hff) begin
            since_ff <= since_ff + 8'h01;
        end
    end
    strobe_low_a: assert property ((since_ff <= STROBE_CYCLES) == !ext_strobe_out_n_o)
        else $error("strobe pulse wrong length");
    conv_start_a: assert property (wr_i && addr_i == dqs_pkg::OFS_START_CONV && ext_convert_n_i
        && $past(ext_convert_n_i) && $past(ext_convert_n_i, 2) |=> start_conv_o) else $error("no conversion start");
    acq_start_a: assert property (wr_i && addr_i == dqs_pkg::OFS_START_ACQ && ext_acq_trigger_n_i
        && $past(ext_acq_trigger_n_i) && $past(ext_acq_trigger_n_i, 2) |=> start_acq_o) else $error("no acq start");
    clear_pulse_a: assert property (wr_i && addr_i == dqs_pkg::OFS_ACQ_CLEAR |=> acq_clear_o && scan_rewind_o)
        else $error("clear pulse missing");
    clear_cause_a: assert property (acq_clear_o || scan_rewind_o |-> $past(wr_i && addr_i == dqs_pkg::OFS_ACQ_CLEAR))
        else $error("clear pulse without write");
    read_idle_a: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
        else $error("read data outside read cycle");
    tc_set_a: assert property (dma_tc_a_i || dma_tc_b_i |=> dma_tc_irq_o)
        else $error("terminal count request missing");
    tc_clear_a: assert property (wr_i && addr_i == dqs_pkg::OFS_DMA_TC_CLR ##1 !dma_tc_a_i && !dma_tc_b_i
        |=> !dma_tc_irq_o) else $error("terminal count not cleared");
    cal_lock_a: assert property (cal_prom_write_req_i && cal_prom_addr_i >= dqs_pkg::CAL_LOCKED_FIRST
        && factory_cal_lock_n_i && $past(factory_cal_lock_n_i, 2) |-> !cal_prom_write_en_o)
        else $error("locked calibration write allowed");
endmodule

bind dqs_top dqs_top_monitor #(.STROBE_CYCLES(STROBE_CYCLES)) u_mon (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .ext_convert_n_i(ext_convert_n_i), .ext_acq_trigger_n_i(ext_acq_trigger_n_i),
    .factory_cal_lock_n_i(factory_cal_lock_n_i), .cal_prom_addr_i(cal_prom_addr_i),
    .cal_prom_write_req_i(cal_prom_write_req_i), .cal_prom_write_en_o(cal_prom_write_en_o),
    .dma_tc_a_i(dma_tc_a_i), .dma_tc_b_i(dma_tc_b_i), .start_conv_o(start_conv_o), .start_acq_o(start_acq_o),
    .acq_clear_o(acq_clear_o), .scan_rewind_o(scan_rewind_o), .dma_tc_irq_o(dma_tc_irq_o),
    .ext_strobe_out_n_o(ext_strobe_out_n_o));
